/* File: src/scc_regs.sv */
module scc_regs #(
    parameter int CNT_WIDTH = 32
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // cache size straps, static pins
    input wire logic [2:0] i_icache_size_strap,
    input wire logic [2:0] i_dcache_size_strap,
    // coprocessor move port
    input wire logic i_cp_wr,
    input wire logic i_cp_rd,
    input wire logic [4:0] i_cp_sel,
    input wire logic [63:0] i_cp_wdata,
    output logic [63:0] o_cp_rdata,
    // exception report
    input wire logic i_exc_valid,
    input wire logic [3:0] i_exc_kind,
    input wire logic [63:0] i_exc_pc,
    input wire logic i_exc_in_delay_slot,
    input wire logic [63:0] i_exc_branch_pc,
    input wire logic i_exception_level_bit,
    input wire logic i_error_level_bit,
    input wire logic [1:0] i_mode_ksu,
    output logic [4:0] o_exception_code_field,
    output logic o_delay_slot_flag,
    output logic [63:0] o_exception_return_address,
    // translation miss
    input wire logic i_tlb_miss,
    input wire logic [63:0] i_miss_watched_doubleword_address,
    // data access watch
    input wire logic i_mem_valid,
    input wire logic i_mem_store,
    input wire logic [63:0] i_mem_watched_doubleword_address,
    output logic o_watch_hit,
    // diagnostic controls
    output logic o_itlb_flush,
    output logic o_branch_target_buffer_flush,
    output logic o_ras_disable,
    output logic o_wait_cache_constraint_off,
    output logic o_wait_issue_constraint_off,
    output logic o_store_issue_constraint_off,
    output logic o_store_fetch_constraint_off,
    // performance events
    input wire logic [15:0] i_evt0,
    input wire logic [15:0] i_evt1,
    output logic o_perf_irq7
);
    // =====================================================================
    // state
    typedef struct packed {
        logic [2:0] ic_s1;
        logic [2:0] ic_s2;
        logic [2:0] dc_s1;
        logic [2:0] dc_s2;
        logic [1:0] strap_cnt;
        logic [2:0] icache_size_field;
        logic [2:0] dcache_size_field;
        logic [2:0] kseg0_coherence_field;
        logic [4:0] exc_code;
        logic delay_slot;
        logic [63:0] exception_return_address;
        logic [60:0] watched_doubleword_address;
        logic watch_load;
        logic watch_store;
        logic watch_hit;
        logic [26:0] page_table_base;
        logic [1:0] region;
        logic [30:0] missed_page_pair_number;
        logic ras_off;
        logic [3:0] cons_off;
        logic itlb_flush;
        logic btb_flush;
        logic [12:0] perf_ctl;
        logic perf_irq;
        logic [63:0] rdata;
    } scc_state_t;

    scc_state_t st_q;
    scc_state_t st_d;

    logic [CNT_WIDTH-1:0] cnt0;
    logic [CNT_WIDTH-1:0] cnt1;
    logic count_qual;
    logic inc0;
    logic inc1;
    logic wr_cnt;
    logic [31:0] config_word;
    logic [31:0] processor_identification_word;
    logic [63:0] watch_word;
    logic [63:0] xctx_word;
    logic [63:0] diag_word;
    logic [63:0] rd_mux;

    localparam int CFG_ONES_HI = scc_pkg::CFG_ONES_LSB + 1;

    // =====================================================================
    // register images
    always_comb
    begin
        config_word = 32'h0000_0000;
        config_word[CFG_ONES_HI:scc_pkg::CFG_ONES_LSB] = 2'h3;
        config_word[scc_pkg::CFG_IC_LSB +: 3] = st_q.icache_size_field;
        config_word[scc_pkg::CFG_DC_LSB +: 3] = st_q.dcache_size_field;
        config_word[scc_pkg::CFG_IB_BIT] = 1'b1;
        config_word[scc_pkg::CFG_DB_BIT] = 1'b1;
        config_word[2:0] = st_q.kseg0_coherence_field;
    end

    assign processor_identification_word = {16'h0000, scc_pkg::PROCESSOR_IDENTIFICATION_IMP, scc_pkg::PROCESSOR_IDENTIFICATION_REV};
    assign watch_word = {st_q.watched_doubleword_address, 1'b0, st_q.watch_load,
                         st_q.watch_store};
    assign xctx_word = {st_q.page_table_base, st_q.region, st_q.missed_page_pair_number,
                        4'h0};
    assign diag_word = {56'h0, st_q.cons_off, 1'b0, 2'h0, st_q.ras_off};

    // =====================================================================
    // read decode; unmapped and load-linked numbers read zero
    always_comb
    begin
        case (i_cp_sel)
            scc_pkg::SEL_EPC: rd_mux = st_q.exception_return_address;
            scc_pkg::SEL_PROCESSOR_IDENTIFICATION: rd_mux = {32'h0, processor_identification_word};
            scc_pkg::SEL_CONFIG: rd_mux = {32'h0, config_word};
            scc_pkg::SEL_LOAD_LINKED_PHYSICAL_ADDRESS: rd_mux = 64'h0;
            scc_pkg::SEL_WATCH: rd_mux = watch_word;
            scc_pkg::SEL_XCONTEXT: rd_mux = xctx_word;
            scc_pkg::SEL_DIAG: rd_mux = diag_word;
            scc_pkg::SEL_PERF_CTL: rd_mux = {51'h0, st_q.perf_ctl};
            scc_pkg::SEL_PERF_CNT: rd_mux = {32'(cnt1), 32'(cnt0)};
            default: rd_mux = 64'h0;
        endcase
    end

    // =====================================================================
    // performance counters
    always_comb
    begin
        count_qual = 1'b0;
        if (!i_error_level_bit)
        begin
            if (i_exception_level_bit)
            begin
                count_qual = st_q.perf_ctl[scc_pkg::PC_EXL_BIT];
            end
            else
            begin
                case (i_mode_ksu)
                    2'h0: count_qual = st_q.perf_ctl[scc_pkg::PC_K_BIT];
                    2'h1: count_qual = st_q.perf_ctl[scc_pkg::PC_S_BIT];
                    2'h2: count_qual = st_q.perf_ctl[scc_pkg::PC_U_BIT];
                    default: count_qual = 1'b0;
                endcase
            end
        end
    end

    // one selected event per counter
    assign inc0 = count_qual && i_evt0[st_q.perf_ctl[scc_pkg::PC_EV0_LSB +: 4]];
    assign inc1 = count_qual && i_evt1[st_q.perf_ctl[scc_pkg::PC_EV1_LSB +: 4]];
    assign wr_cnt = i_cp_wr && (i_cp_sel == scc_pkg::SEL_PERF_CNT);

    scc_counter #(.WIDTH(CNT_WIDTH)) u_cnt0 (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_wr(wr_cnt),
        .i_wdata(i_cp_wdata[CNT_WIDTH-1:0]),
        .i_inc(inc0),
        .o_count(cnt0)
    );

    scc_counter #(.WIDTH(CNT_WIDTH)) u_cnt1 (
        .i_core_clk(i_core_clk),
        .i_nrst(i_nrst),
        .i_wr(wr_cnt),
        .i_wdata(i_cp_wdata[32 +: CNT_WIDTH]),
        .i_inc(inc1),
        .o_count(cnt1)
    );

    // =====================================================================
    // next state
    always_comb
    begin
        st_d = st_q;
        // straps: first flop feeds only the second
        st_d.ic_s1 = i_icache_size_strap;
        st_d.ic_s2 = st_q.ic_s1;
        st_d.dc_s1 = i_dcache_size_strap;
        st_d.dc_s2 = st_q.dc_s1;
        if (st_q.strap_cnt != 2'h3)
        begin
            st_d.strap_cnt = st_q.strap_cnt + 2'h1;
        end
        if (st_q.strap_cnt == scc_pkg::STRAP_SETTLE)
        begin
            st_d.icache_size_field = st_q.ic_s2;
            st_d.dcache_size_field = st_q.dc_s2;
        end
        st_d.itlb_flush = 1'b0;
        st_d.btb_flush = 1'b0;

        // software writes
        if (i_cp_wr)
        begin
            case (i_cp_sel)
                scc_pkg::SEL_EPC: st_d.exception_return_address = i_cp_wdata;
                scc_pkg::SEL_CONFIG: st_d.kseg0_coherence_field = i_cp_wdata[2:0];
                scc_pkg::SEL_WATCH:
                begin
                    st_d.watched_doubleword_address = i_cp_wdata[63:3];
                    st_d.watch_load = i_cp_wdata[1];
                    st_d.watch_store = i_cp_wdata[0];
                end
                scc_pkg::SEL_XCONTEXT:
                begin
                    st_d.page_table_base = i_cp_wdata[63:scc_pkg::XC_PAGE_TABLE_BASE_LSB];
                    st_d.region = i_cp_wdata[scc_pkg::XC_REGION_LSB +: 2];
                    st_d.missed_page_pair_number = i_cp_wdata[scc_pkg::XC_MISSED_PAGE_PAIR_NUMBER_LSB +: 31];
                end
                scc_pkg::SEL_DIAG:
                begin
                    st_d.itlb_flush = i_cp_wdata[scc_pkg::DIAG_ITLB_BIT];
                    st_d.btb_flush = i_cp_wdata[scc_pkg::DIAG_BTB_BIT];
                    st_d.ras_off = i_cp_wdata[scc_pkg::DIAG_RAS_BIT];
                    st_d.cons_off = i_cp_wdata[scc_pkg::DIAG_CONS_LSB +: 4];
                end
                scc_pkg::SEL_PERF_CTL: st_d.perf_ctl = i_cp_wdata[12:0];
                default: st_d.kseg0_coherence_field = st_q.kseg0_coherence_field;
            endcase
        end

        // hardware updates win over a same-cycle software write
        if (i_exc_valid)
        begin
            st_d.exc_code = scc_pkg::code_of(scc_pkg::scc_exc_kind_t'(i_exc_kind));
            if (!i_exception_level_bit)
            begin
                st_d.delay_slot = i_exc_in_delay_slot;
                st_d.exception_return_address = i_exc_in_delay_slot ? i_exc_branch_pc : i_exc_pc;
            end
        end
        if (i_tlb_miss)
        begin
            st_d.missed_page_pair_number = i_miss_watched_doubleword_address[43:13];
            st_d.region = i_miss_watched_doubleword_address[63:62];
        end

        // watch compare on the doubleword
        st_d.watch_hit = i_mem_valid && (i_mem_watched_doubleword_address[63:3] == st_q.watched_doubleword_address)
                         && (i_mem_store ? st_q.watch_store : st_q.watch_load);

        // line seven follows the top bits while enabled
        st_d.perf_irq = st_q.perf_ctl[scc_pkg::PC_IE_BIT] && (cnt0[CNT_WIDTH-1]
                        || cnt1[CNT_WIDTH-1]);

        if (i_cp_rd)
        begin
            st_d.rdata = rd_mux;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            st_q <= '0;
            st_q.kseg0_coherence_field <= scc_pkg::CFG_SW_RESET;
            st_q.perf_ctl <= scc_pkg::PERF_CTL_RESET;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // =====================================================================
    // outputs
    assign o_cp_rdata = st_q.rdata;
    assign o_exception_code_field = st_q.exc_code;
    assign o_delay_slot_flag = st_q.delay_slot;
    assign o_exception_return_address = st_q.exception_return_address;
    assign o_watch_hit = st_q.watch_hit;
    assign o_itlb_flush = st_q.itlb_flush;
    assign o_branch_target_buffer_flush = st_q.btb_flush;
    assign o_ras_disable = st_q.ras_off;
    assign o_wait_cache_constraint_off = st_q.cons_off[3];
    assign o_wait_issue_constraint_off = st_q.cons_off[2];
    assign o_store_issue_constraint_off = st_q.cons_off[1];
    assign o_store_fetch_constraint_off = st_q.cons_off[0];
    assign o_perf_irq7 = st_q.perf_irq;

    // =====================================================================
    // checks
    sequence exc_in_s(logic [3:0] k);
        i_exc_valid && (i_exc_kind == k);
    endsequence

    store_addr_code_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        exc_in_s(5) |=> (o_exception_code_field == 5'h05))
        else $error("store address error code wrong");
    bus_err_code_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        exc_in_s(7) |=> (o_exception_code_field == 5'h07))
        else $error("data bus error code wrong");
    syscall_code_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        exc_in_s(8) |=> (o_exception_code_field == 5'h08))
        else $error("syscall code wrong");
    overflow_code_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        exc_in_s(12) |=> (o_exception_code_field == 5'h0C))
        else $error("overflow code wrong");
    watch_code_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        exc_in_s(15) |=> (o_exception_code_field == 5'h17))
        else $error("watch code wrong");
    code_legal_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (o_exception_code_field <= 5'h0D) || (o_exception_code_field == 5'h0F)
        || (o_exception_code_field == 5'h17))
        else $error("reserved exception code produced");
    epc_slot_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (i_exc_valid && !i_exception_level_bit && i_exc_in_delay_slot)
        |=> (o_exception_return_address == $past(i_exc_branch_pc)) && o_delay_slot_flag)
        else $error("delay slot return address wrong");
    epc_frozen_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (i_exc_valid && i_exception_level_bit && !i_cp_wr)
        |=> $stable(o_exception_return_address))
        else $error("return address changed at exception level");
    config_fixed_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (i_cp_rd && i_cp_sel == scc_pkg::SEL_CONFIG)
        |=> (o_cp_rdata[31:16] == 16'h0003) && (o_cp_rdata[5:3] == 3'h6))
        else $error("config fixed bits wrong");
    miss_capture_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        i_tlb_miss |=> (st_q.missed_page_pair_number == $past(i_miss_watched_doubleword_address[43:13]))
        && (st_q.region == $past(i_miss_watched_doubleword_address[63:62])))
        else $error("missed page pair not captured");
    watch_load_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (i_mem_valid && !i_mem_store && st_q.watch_load
         && i_mem_watched_doubleword_address[63:3] == st_q.watched_doubleword_address) |=> o_watch_hit)
        else $error("watched load not flagged");
    itlb_pulse_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (i_cp_wr && i_cp_sel == scc_pkg::SEL_DIAG && i_cp_wdata[2])
        |=> o_itlb_flush ##1 (!o_itlb_flush || $past(i_cp_wr)))
        else $error("itlb flush pulse wrong");
endmodule

/* File: inc/scc_pkg.sv */
package scc_pkg;
    // =====================================================================
    // coprocessor register numbers
    localparam logic [4:0] SEL_EPC = 5'h0E;
    localparam logic [4:0] SEL_PROCESSOR_IDENTIFICATION = 5'h0F;
    localparam logic [4:0] SEL_CONFIG = 5'h10;
    localparam logic [4:0] SEL_LOAD_LINKED_PHYSICAL_ADDRESS = 5'h11;
    localparam logic [4:0] SEL_WATCH = 5'h12;
    localparam logic [4:0] SEL_XCONTEXT = 5'h14;
    localparam logic [4:0] SEL_DIAG = 5'h16;
    localparam logic [4:0] SEL_PERF_CTL = 5'h18;
    localparam logic [4:0] SEL_PERF_CNT = 5'h19;

    // =====================================================================
    // exception codes
    localparam logic [4:0] CODE_INT = 5'h00;
    localparam logic [4:0] CODE_TLB_MOD = 5'h01;
    localparam logic [4:0] CODE_TLB_LOAD = 5'h02;
    localparam logic [4:0] CODE_TLB_STORE = 5'h03;
    localparam logic [4:0] CODE_ADDR_LOAD = 5'h04;
    localparam logic [4:0] CODE_ADDR_STORE = 5'h05;
    localparam logic [4:0] CODE_BUS_FETCH = 5'h06;
    localparam logic [4:0] CODE_BUS_DATA = 5'h07;
    localparam logic [4:0] CODE_SYSCALL = 5'h08;
    localparam logic [4:0] CODE_BREAK = 5'h09;
    localparam logic [4:0] CODE_RESV_INST = 5'h0A;
    localparam logic [4:0] CODE_COP_UNUSABLE = 5'h0B;
    localparam logic [4:0] CODE_OVERFLOW = 5'h0C;
    localparam logic [4:0] CODE_TRAP = 5'h0D;
    localparam logic [4:0] CODE_FPE = 5'h0F;
    localparam logic [4:0] CODE_WATCH = 5'h17;

    typedef enum logic [3:0] {
        EXC_INT, EXC_TLB_MOD, EXC_TLB_LOAD, EXC_TLB_STORE,
        EXC_ADDR_LOAD, EXC_ADDR_STORE, EXC_BUS_FETCH, EXC_BUS_DATA,
        EXC_SYSCALL, EXC_BREAK, EXC_RESV_INST, EXC_COP_UNUSABLE,
        EXC_OVERFLOW, EXC_TRAP, EXC_FPE, EXC_WATCH
    } scc_exc_kind_t;

    // =====================================================================
    // identification, arbitrary neutral values
    localparam logic [7:0] PROCESSOR_IDENTIFICATION_IMP = 8'hA5;
    localparam logic [7:0] PROCESSOR_IDENTIFICATION_REV = 8'h01;

    // =====================================================================
    // field positions
    localparam int CFG_DC_LSB = 6;
    localparam int CFG_IC_LSB = 9;
    localparam int CFG_ONES_LSB = 16;
    localparam int CFG_DB_BIT = 4;
    localparam int CFG_IB_BIT = 5;
    localparam int XC_MISSED_PAGE_PAIR_NUMBER_LSB = 4;
    localparam int XC_REGION_LSB = 35;
    localparam int XC_PAGE_TABLE_BASE_LSB = 37;
    localparam int DIAG_RAS_BIT = 0;
    localparam int DIAG_BTB_BIT = 1;
    localparam int DIAG_ITLB_BIT = 2;
    localparam int DIAG_CONS_LSB = 4;
    localparam int PC_EXL_BIT = 0;
    localparam int PC_U_BIT = 1;
    localparam int PC_S_BIT = 2;
    localparam int PC_K_BIT = 3;
    localparam int PC_IE_BIT = 4;
    localparam int PC_EV0_LSB = 5;
    localparam int PC_EV1_LSB = 9;

    // =====================================================================
    // reset values and counts
    localparam logic [2:0] CFG_SW_RESET = 3'h0;
    localparam logic [12:0] PERF_CTL_RESET = 13'h0000;
    localparam logic [1:0] STRAP_SETTLE = 2'h2;
    localparam logic [31:0] CNT_RESET = 32'h0000_0000;

    function automatic logic [4:0] code_of(scc_exc_kind_t k);
        case (k)
            EXC_INT: code_of = CODE_INT;
            EXC_TLB_MOD: code_of = CODE_TLB_MOD;
            EXC_TLB_LOAD: code_of = CODE_TLB_LOAD;
            EXC_TLB_STORE: code_of = CODE_TLB_STORE;
            EXC_ADDR_LOAD: code_of = CODE_ADDR_LOAD;
            EXC_ADDR_STORE: code_of = CODE_ADDR_STORE;
            EXC_BUS_FETCH: code_of = CODE_BUS_FETCH;
            EXC_BUS_DATA: code_of = CODE_BUS_DATA;
            EXC_SYSCALL: code_of = CODE_SYSCALL;
            EXC_BREAK: code_of = CODE_BREAK;
            EXC_RESV_INST: code_of = CODE_RESV_INST;
            EXC_COP_UNUSABLE: code_of = CODE_COP_UNUSABLE;
            EXC_OVERFLOW: code_of = CODE_OVERFLOW;
            EXC_TRAP: code_of = CODE_TRAP;
            EXC_FPE: code_of = CODE_FPE;
            default: code_of = CODE_WATCH;
        endcase
    endfunction
endpackage

/* File: src/scc_counter.sv */
module scc_counter #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // software access
    input wire logic i_wr,
    input wire logic [WIDTH-1:0] i_wdata,
    // event
    input wire logic i_inc,
    // count
    output logic [WIDTH-1:0] o_count
);
    // =====================================================================
    // state
    typedef struct packed {
        logic [WIDTH-1:0] count;
    } scc_cnt_state_t;

    scc_cnt_state_t st_q;
    scc_cnt_state_t st_d;

    // software write wins over a same-cycle event; wraps past the top bit
    always_comb
    begin
        st_d = st_q;
        if (i_wr)
        begin
            st_d.count = i_wdata;
        end
        else if (i_inc)
        begin
            st_d.count = st_q.count + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign o_count = st_q.count;

    count_step_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
        (!i_wr && i_inc) |=> (o_count == $past(o_count) + {{(WIDTH-1){1'b0}}, 1'b1}))
        else $error("counter did not step by one");
endmodule

/* File: tb/scc_pipe_model.sv */
// ==========
// pipeline side: exceptions, misses, data accesses
module scc_pipe_model (
    // clock
    input wire logic i_core_clk,
    // reports
    output logic o_exc_valid,
    output logic [3:0] o_exc_kind,
    output logic [63:0] o_exc_pc,
    output logic o_exc_ds,
    output logic [63:0] o_exc_bpc,
    output logic o_miss,
    output logic [63:0] o_miss_va,
    output logic o_mem_valid,
    output logic o_mem_store,
    output logic [63:0] o_mem_va
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        {o_exc_valid, o_exc_kind, o_exc_pc, o_exc_ds, o_exc_bpc} = '0;
        {o_miss, o_miss_va, o_mem_valid, o_mem_store, o_mem_va} = '0;
    end
    // released address buses show the inverse, so stale values never match
    task automatic exc(input logic [3:0] k, input logic [63:0] pc, input logic ds);
        @(posedge i_core_clk);
        {o_exc_valid, o_exc_kind, o_exc_pc, o_exc_ds} <= {1'b1, k, pc, ds};
        o_exc_bpc <= pc - 64'h4;
        @(posedge i_core_clk);
        {o_exc_valid, o_exc_pc, o_exc_bpc} <= {1'b0, ~pc, ~(pc - 64'h4)};
        #1;
    endtask
    task automatic miss(input logic [63:0] va);
        @(posedge i_core_clk);
        {o_miss, o_miss_va} <= {1'b1, va};
        @(posedge i_core_clk);
        {o_miss, o_miss_va} <= {1'b0, ~va};
        #1;
    endtask
    task automatic mem(input logic st, input logic [63:0] va);
        @(posedge i_core_clk);
        {o_mem_valid, o_mem_store, o_mem_va} <= {1'b1, st, va};
        @(posedge i_core_clk);
        {o_mem_valid, o_mem_va} <= {1'b0, ~va};
        #1;
    endtask
endmodule

/* File: tb/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, nrst, wr, rd, exception_level_bit, ds, hit, itlb, branch_target_buffer, irq;
    logic [4:0] sel, code, lv;
    logic [1:0] ksu;
    logic [15:0] evt0, evt1;
    logic [63:0] wd, rdata, exception_return_address, prev;
    logic ev, ms, mv, mst, eds;
    logic [3:0] ek;
    logic [63:0] epc_in, ebpc, mva, va;
    int fail_count, compares;
    scc_pipe_model scc_pipe_model_inst (.i_core_clk(clk), .o_exc_valid(ev), .o_exc_kind(ek),
        .o_exc_pc(epc_in), .o_exc_ds(eds), .o_exc_bpc(ebpc), .o_miss(ms), .o_miss_va(mva),
        .o_mem_valid(mv), .o_mem_store(mst), .o_mem_va(va));
    scc_regs scc_regs_inst (.i_core_clk(clk), .i_nrst(nrst), .i_icache_size_strap(3'h2),
        .i_dcache_size_strap(3'h3), .i_cp_wr(wr), .i_cp_rd(rd), .i_cp_sel(sel),
        .i_cp_wdata(wd), .o_cp_rdata(rdata), .i_exc_valid(ev), .i_exc_kind(ek),
        .i_exc_pc(epc_in), .i_exc_in_delay_slot(eds), .i_exc_branch_pc(ebpc),
        .i_exception_level_bit(exception_level_bit), .i_error_level_bit(1'b0), .i_mode_ksu(ksu),
        .o_exception_code_field(code), .o_delay_slot_flag(ds),
        .o_exception_return_address(exception_return_address), .i_tlb_miss(ms), .i_miss_watched_doubleword_address(mva),
        .i_mem_valid(mv), .i_mem_store(mst), .i_mem_watched_doubleword_address(va), .o_watch_hit(hit),
        .o_itlb_flush(itlb), .o_branch_target_buffer_flush(branch_target_buffer), .o_ras_disable(lv[0]),
        .o_wait_cache_constraint_off(lv[4]), .o_wait_issue_constraint_off(lv[3]),
        .o_store_issue_constraint_off(lv[2]), .o_store_fetch_constraint_off(lv[1]),
        .i_evt0(evt0), .i_evt1(evt1), .o_perf_irq7(irq));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ==========
    // access tasks
    task automatic check(input string n, input logic [63:0] s, input logic [63:0] e);
        compares++;
        if (s !== e)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr_reg(input logic [4:0] s, input logic [63:0] d);
        @(posedge clk);
        {wr, sel, wd} <= {1'b1, s, d};
        @(posedge clk);
        {wr, wd} <= {1'b0, ~d};
        #1;
    endtask
    task automatic rd_reg(input logic [4:0] s, input logic [63:0] e, input string n);
        @(posedge clk);
        {rd, sel} <= {1'b1, s};
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(n, rdata, e);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ==========
    // scenarios
    initial
    begin
        {nrst, wr, rd, exception_level_bit, sel, wd, ksu, evt0, evt1} = '0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (5) @(posedge clk);
        rd_reg(scc_pkg::SEL_PROCESSOR_IDENTIFICATION, {48'h0, scc_pkg::PROCESSOR_IDENTIFICATION_IMP, scc_pkg::PROCESSOR_IDENTIFICATION_REV}, "ident");
        rd_reg(scc_pkg::SEL_CONFIG, 64'h0003_04F0, "config");
        wr_reg(scc_pkg::SEL_CONFIG, '1);
        rd_reg(scc_pkg::SEL_CONFIG, 64'h0003_04F7, "config_wr");
        rd_reg(scc_pkg::SEL_LOAD_LINKED_PHYSICAL_ADDRESS, 64'h0, "load_linked_physical_address");
        wr_reg(scc_pkg::SEL_EPC, 64'h0000_0000_0000_8880);
        rd_reg(scc_pkg::SEL_EPC, 64'h0000_0000_0000_8880, "epc_sw");
        for (int k = 0; k < 16; k++)
        begin
            scc_pipe_model_inst.exc(4'(k), 64'h1000 + 64'(k * 8), k[0]);
            check("code", 64'(code), k < 14 ? k : (k == 14 ? 15 : 23));
            check("epc", exception_return_address, k[0] ? 64'h0FFC + 64'(k * 8) : 64'h1000 + 64'(k * 8));
            check("bd", 64'(ds), 64'(k[0]));
        end
        prev = exception_return_address;
        exception_level_bit <= 1'b1;
        scc_pipe_model_inst.exc(4'h8, 64'h2000, 1'b0);
        check("epc_exl", exception_return_address, prev);
        check("code_exl", 64'(code), 64'h8);
        exception_level_bit <= 1'b0;
        wr_reg(scc_pkg::SEL_XCONTEXT, 64'hFFFF_FFE0_0000_0000);
        scc_pipe_model_inst.miss(64'h4000_0ABC_DEF0_1000);
        rd_reg(scc_pkg::SEL_XCONTEXT, {27'h7FF_FFFF, 2'b01, 31'h55E6_F780, 4'h0}, "xctx");
        wr_reg(scc_pkg::SEL_WATCH, 64'h0000_1230_0000_0042);
        scc_pipe_model_inst.mem(1'b0, 64'h0000_1230_0000_0045);
        check("watch_ld", 64'(hit), 64'h1);
        scc_pipe_model_inst.mem(1'b1, 64'h0000_1230_0000_0040);
        check("watch_st", 64'(hit), 64'h0);
        rd_reg(scc_pkg::SEL_WATCH, 64'h0000_1230_0000_0042, "watch");
        wr_reg(scc_pkg::SEL_DIAG, 64'hFFFF_FFFF_FFFF_FFF1);
        check("diag_lv", 64'(lv), 64'h1F);
        rd_reg(scc_pkg::SEL_DIAG, 64'hF1, "diag");
        wr_reg(scc_pkg::SEL_DIAG, 64'h06);
        check("flush", 64'({itlb, branch_target_buffer, lv}), 64'h60);
        wr_reg(scc_pkg::SEL_PERF_CTL, 64'h18);
        rd_reg(scc_pkg::SEL_PERF_CTL, 64'h18, "perf_ctl");
        wr_reg(scc_pkg::SEL_PERF_CNT, 64'h0000_0005_7FFF_FFFF);
        check("irq_off", 64'(irq), 64'h0);
        @(posedge clk);
        {evt0, evt1} <= {16'h0001, 16'h0001};
        @(posedge clk);
        {evt0, evt1} <= {16'h0000, 16'h0000};
        rd_reg(scc_pkg::SEL_PERF_CNT, 64'h0000_0006_8000_0000, "count");
        repeat (2) @(posedge clk);
        #1;
        check("irq7", 64'(irq), 64'h1);
        summarize();
    end
endmodule
